//--- pkg/ccsi_pkg.sv
// constants, types and register map of the card status indicator block
// assumes a 10 MHz system clock and a classic wishbone register bus
`default_nettype none
package ccsi_pkg;

	// ----------------------------------------------------------------
	// clock and lamp timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 10_000_000; // system clock rate
	localparam int LINK_HALF_MS  = 500;        // link lamp lit and dark
	localparam int BLINK_MS      = 200;        // blink lit and dark
	localparam int FLASH_DARK_MS = 1000;       // dark gap after a flash
	localparam int LINK_HALF_CYC = LINK_HALF_MS * (CLK_HZ / 1000);
	localparam int BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);
	localparam int FLASH_DK_CYC  = FLASH_DARK_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// register map, byte offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL   = 4'h0; // control
	localparam logic [3:0] OFS_STATUS = 4'h4; // sticky events, w1c
	localparam logic [3:0] OFS_MASK   = 4'h8; // interrupt mask
	localparam logic [3:0] OFS_STATE  = 4'hc; // lamps and states, ro

	// control fields and reset value
	localparam int         CTRL_EN_BIT   = 0; // lamps enabled
	localparam int         CTRL_TEST_BIT = 1; // all lamps forced lit
	localparam logic [1:0] CTRL_RST      = 2'h1;

	// event bits of status and mask
	localparam int         EV_RX      = 0; // rx error pulse seen
	localparam int         EV_BUSOFF = 1; // bus-off entered
	localparam int         EV_LOST    = 2; // board link lost
	localparam int         EV_DRVFLT  = 3; // drive fault raised
	localparam int         EV_ADDR    = 4; // bad node address raised
	localparam int         EV_W       = 5;
	localparam logic [4:0] STATUS_RST = 5'h00;
	localparam logic [4:0] MASK_RST   = 5'h00;

	// state register fields
	localparam int LAMP_LSB = 0; // link, power, run, error lamps
	localparam int LINK_LSB = 4; // board link state
	localparam int NODE_LSB = 6; // node state as seen on input

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	// board link progress, gray along setup, up, lost
	typedef enum logic [1:0]
	{
		LINK_SETUP = 2'h0,
		LINK_UP    = 2'h1,
		LINK_LOST  = 2'h3
	} ccsi_link_type;

	// communication node states, gray coded
	typedef enum logic [1:0]
	{
		NODE_BOOT = 2'h0,
		NODE_PREOP = 2'h1,
		NODE_WORK = 2'h3,
		NODE_STOP = 2'h2
	} ccsi_node_type;

	// pattern generator state
	typedef struct packed
	{
		logic [31:0] cnt; // position inside one period
		logic        lit; // lamp phase
	} ccsi_pat_type;

	// top level state
	typedef struct packed
	{
		ccsi_link_type link;    // board link state
		logic [1:0]    ctrl;    // control register
		logic [4:0]    status;  // sticky events
		logic [4:0]    mask;    // interrupt mask
		logic [3:0]    lamps;   // lamp outputs
		logic          rx_pend; // rx error flash owed
		logic [2:0]    prev;    // bus-off, drive fault, bad address
		logic          ack;     // bus acknowledge
		logic [31:0]   rdat;    // bus read data
		logic          irq;     // interrupt output
	} ccsi_top_type;

	localparam int LAMP_LINK = 0;
	localparam int LAMP_PWR  = 1;
	localparam int LAMP_RUN  = 2;
	localparam int LAMP_ERR  = 3;

endpackage
`default_nettype wire

//--- design/ccsi_pattern.sv
// lamp pattern generator: lit for ON_CYC cycles, dark for OFF_CYC
// assumes one clock; restart holds the pattern at the start of lit
`timescale 1ns/100ps
`default_nettype none
module ccsi_pattern
#(
	parameter int ON_CYC  = 2_000_000, // lit cycles
	parameter int OFF_CYC = 2_000_000  // dark cycles
)
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic restart,
	output logic      lit,
	output logic      wrap
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam logic [31:0] LAST = 32'(ON_CYC + OFF_CYC - 1);
	localparam logic [31:0] ONC  = 32'(ON_CYC);

	ccsi_pkg::ccsi_pat_type st_ff;  // registered state
	ccsi_pkg::ccsi_pat_type nxt_st; // next state

	// next state: count through one period, then wrap
	always_comb
	begin
		nxt_st = st_ff;
		if (restart)
		begin
			// hold at the start of the lit phase
			nxt_st.cnt = 32'h0;
			nxt_st.lit = 1'b1;
		end
		else if (st_ff.cnt == LAST)
		begin
			// period over, light again
			nxt_st.cnt = 32'h0;
			nxt_st.lit = 1'b1;
		end
		else
		begin
			nxt_st.cnt = st_ff.cnt + 32'h1;
			nxt_st.lit = (st_ff.cnt + 32'h1) < ONC;
		end
	end

	// state register
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			st_ff <= '{cnt: 32'h0, lit: 1'b1};
		else
			st_ff <= nxt_st;
	end

	assign lit  = st_ff.lit;
	assign wrap = !restart && (st_ff.cnt == LAST);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	AST_PAT_LIT_LEN: assert property (
		(st_ff.cnt < ONC) == st_ff.lit)
		else $error("lamp phase does not match position");

	AST_PAT_WRAP: assert property (
		wrap |=> (st_ff.cnt == 32'h0) && st_ff.lit)
		else $error("pattern did not restart lit after period");

endmodule
`default_nettype wire

//--- design/ccsi_top.sv
// status indicator encoder of a can communication card
// assumes synchronous inputs on clk_sys and a classic wishbone master
//
// How it works
// - link lamp steady while connecting to board
// - link lamp blinks 0.5s/0.5s when connected
// - link lamp dark when board link lost
// - power lamp lit while board supplies power
// - run lamp steady in working state
// - run lamp dark on card fault
// - run lamp blinks in pre-operational state
// - run lamp single flash in stopped state
// - error lamp steady on bus-off or drive fault
// - error lamp dark when working without errors
// - error lamp blinks on bad node address
// - error lamp single flash on rx error
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module ccsi_top
#(
	parameter int LINK_HALF_CYC = ccsi_pkg::LINK_HALF_CYC, // link half
	parameter int BLINK_CYC     = ccsi_pkg::BLINK_CYC,     // blink half
	parameter int FLASH_DK_CYC  = ccsi_pkg::FLASH_DK_CYC   // flash gap
)
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        board_link_ok,
	input  wire logic        power_present,
	input  wire logic        card_fault,
	input  wire logic [1:0]  node_state,
	input  wire logic        bus_off,
	input  wire logic        drive_fault,
	input  wire logic        addr_invalid,
	input  wire logic        rx_error,
	output logic             card_link_lamp,
	output logic             power_lamp,
	output logic             run_lamp,
	output logic             error_lamp,
	output logic             irq
);

	// ----------------------------------------------------------------
	// state and pattern sources
	// ----------------------------------------------------------------
	ccsi_pkg::ccsi_top_type  st_ff;   // all registered state
	ccsi_pkg::ccsi_top_type  nxt_st;  // next state
	ccsi_pkg::ccsi_node_type node;    // node state decoded
	logic                    link_lit; // connected pattern
	logic                    blk_lit;  // shared blink pattern
	logic                    stp_lit;  // stopped flash pattern
	logic                    rxf_lit;  // rx error flash pattern
	logic                    rxf_wrap; // rx flash period over
	logic                    rxf_start; // new rx error flash
	logic                    lamps_on; // lamps enabled, no test
	logic                    err_steady; // bus-off or drive fault
	logic                    wr_hit;   // write taken this edge
	logic [4:0]              events;   // this cycle's events

	assign node     = ccsi_pkg::ccsi_node_type'(node_state);
	assign lamps_on = st_ff.ctrl[ccsi_pkg::CTRL_EN_BIT]
		&& !st_ff.ctrl[ccsi_pkg::CTRL_TEST_BIT];
	assign err_steady = bus_off || drive_fault;
	assign rxf_start  = rx_error && !st_ff.rx_pend;

	// link lamp pattern, held lit until the link comes up
	ccsi_pattern
	#(
		.ON_CYC  (LINK_HALF_CYC),
		.OFF_CYC (LINK_HALF_CYC)
	)
	u_link_pat
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.restart (st_ff.link != ccsi_pkg::LINK_UP),
		.lit     (link_lit),
		.wrap    ()
	);

	// free running blink shared by run and error lamps
	ccsi_pattern
	#(
		.ON_CYC  (BLINK_CYC),
		.OFF_CYC (BLINK_CYC)
	)
	u_blink_pat
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.restart (1'b0),
		.lit     (blk_lit),
		.wrap    ()
	);

	// single flash of the stopped state, starts with the state
	ccsi_pattern
	#(
		.ON_CYC  (BLINK_CYC),
		.OFF_CYC (FLASH_DK_CYC)
	)
	u_stop_pat
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.restart (node != ccsi_pkg::NODE_STOP),
		.lit     (stp_lit),
		.wrap    ()
	);

	// single flash owed to a receive error
	ccsi_pattern
	#(
		.ON_CYC  (BLINK_CYC),
		.OFF_CYC (FLASH_DK_CYC)
	)
	u_rx_pat
	(
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.restart (!st_ff.rx_pend || rxf_start),
		.lit     (rxf_lit),
		.wrap    (rxf_wrap)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack
		&& wb_sel_i[0];

	// events that set sticky status bits
	always_comb
	begin
		events = 5'h00;
		events[ccsi_pkg::EV_RX]     = rx_error;
		events[ccsi_pkg::EV_BUSOFF] = bus_off && !st_ff.prev[0];
		events[ccsi_pkg::EV_DRVFLT] = drive_fault && !st_ff.prev[1];
		events[ccsi_pkg::EV_ADDR]   = addr_invalid && !st_ff.prev[2];
		events[ccsi_pkg::EV_LOST]   =
			(st_ff.link == ccsi_pkg::LINK_UP) && !board_link_ok;
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.prev = {addr_invalid, drive_fault, bus_off};

		// board link state machine
		unique case (st_ff.link)
			ccsi_pkg::LINK_SETUP:
				if (board_link_ok)
					nxt_st.link = ccsi_pkg::LINK_UP;
			ccsi_pkg::LINK_UP:
				if (!board_link_ok)
					nxt_st.link = ccsi_pkg::LINK_LOST;
			ccsi_pkg::LINK_LOST:
				if (board_link_ok)
					nxt_st.link = ccsi_pkg::LINK_UP;
			default:
				nxt_st.link = ccsi_pkg::LINK_SETUP;
		endcase

		// rx flash owed: set wins over the end of a flash
		if (rx_error)
			nxt_st.rx_pend = 1'b1;
		else if (rxf_wrap)
			nxt_st.rx_pend = 1'b0;

		// link lamp
		unique case (st_ff.link)
			ccsi_pkg::LINK_SETUP:
				nxt_st.lamps[ccsi_pkg::LAMP_LINK] = 1'b1;
			ccsi_pkg::LINK_UP:
				nxt_st.lamps[ccsi_pkg::LAMP_LINK] = link_lit;
			default:
				nxt_st.lamps[ccsi_pkg::LAMP_LINK] = 1'b0;
		endcase

		// power lamp
		nxt_st.lamps[ccsi_pkg::LAMP_PWR] = power_present;

		// run lamp, fault first
		if (card_fault)
			nxt_st.lamps[ccsi_pkg::LAMP_RUN] = 1'b0;
		else
		begin
			unique case (node)
				ccsi_pkg::NODE_WORK:
					nxt_st.lamps[ccsi_pkg::LAMP_RUN] = 1'b1;
				ccsi_pkg::NODE_PREOP:
					nxt_st.lamps[ccsi_pkg::LAMP_RUN] = blk_lit;
				ccsi_pkg::NODE_STOP:
					nxt_st.lamps[ccsi_pkg::LAMP_RUN] = stp_lit;
				ccsi_pkg::NODE_BOOT:
					nxt_st.lamps[ccsi_pkg::LAMP_RUN] = 1'b0;
			endcase
		end

		// error lamp in order of precedence
		if (err_steady)
			nxt_st.lamps[ccsi_pkg::LAMP_ERR] = 1'b1;
		else if (addr_invalid)
			nxt_st.lamps[ccsi_pkg::LAMP_ERR] = blk_lit;
		else if (st_ff.rx_pend)
			nxt_st.lamps[ccsi_pkg::LAMP_ERR] = rxf_lit;
		else
			nxt_st.lamps[ccsi_pkg::LAMP_ERR] = 1'b0;

		// lamp control: test lights all, disable darkens all
		if (st_ff.ctrl[ccsi_pkg::CTRL_TEST_BIT])
			nxt_st.lamps = 4'hf;
		else if (!st_ff.ctrl[ccsi_pkg::CTRL_EN_BIT])
			nxt_st.lamps = 4'h0;

		// bus: answer one cycle after the request
		nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
		nxt_st.rdat = 32'h0;
		if (wb_cyc_i && wb_stb_i && !st_ff.ack && !wb_we_i)
		begin
			unique case (wb_adr_i)
				ccsi_pkg::OFS_CTRL:
					nxt_st.rdat[1:0] = st_ff.ctrl;
				ccsi_pkg::OFS_STATUS:
					nxt_st.rdat[4:0] = st_ff.status;
				ccsi_pkg::OFS_MASK:
					nxt_st.rdat[4:0] = st_ff.mask;
				ccsi_pkg::OFS_STATE:
					nxt_st.rdat[7:0] = {node_state, st_ff.link,
						st_ff.lamps};
				default:
					nxt_st.rdat = 32'h0; // unmapped reads zero
			endcase
		end

		// writes take effect at the acknowledging edge
		if (wr_hit && wb_adr_i == ccsi_pkg::OFS_CTRL)
			nxt_st.ctrl = wb_dat_i[1:0];
		if (wr_hit && wb_adr_i == ccsi_pkg::OFS_MASK)
			nxt_st.mask = wb_dat_i[4:0];
		if (wr_hit && wb_adr_i == ccsi_pkg::OFS_STATUS)
			nxt_st.status = st_ff.status & ~wb_dat_i[4:0];
		// new events win over a clear in the same cycle
		nxt_st.status = nxt_st.status | events;

		nxt_st.irq = |(nxt_st.status & nxt_st.mask);
	end

	// state register
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_ff.link    <= ccsi_pkg::LINK_SETUP;
			st_ff.ctrl    <= ccsi_pkg::CTRL_RST;
			st_ff.status  <= ccsi_pkg::STATUS_RST;
			st_ff.mask    <= ccsi_pkg::MASK_RST;
			st_ff.lamps   <= 4'h0;
			st_ff.rx_pend <= 1'b0;
			st_ff.prev    <= 3'h0;
			st_ff.ack     <= 1'b0;
			st_ff.rdat    <= 32'h0;
			st_ff.irq     <= 1'b0;
		end
		else
			st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign card_link_lamp = st_ff.lamps[ccsi_pkg::LAMP_LINK];
	assign power_lamp     = st_ff.lamps[ccsi_pkg::LAMP_PWR];
	assign run_lamp       = st_ff.lamps[ccsi_pkg::LAMP_RUN];
	assign error_lamp     = st_ff.lamps[ccsi_pkg::LAMP_ERR];
	assign wb_dat_o       = st_ff.rdat;
	assign wb_ack_o       = st_ff.ack;
	assign irq            = st_ff.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// rx error seen with no flash owed, then flash begins lit
	sequence rx_first;
		lamps_on && rxf_start && !err_steady && !addr_invalid;
	endsequence
	sequence rx_flash_on;
		st_ff.rx_pend ##1 error_lamp;
	endsequence

	AST_LINK_SETUP: assert property (
		lamps_on && st_ff.link == ccsi_pkg::LINK_SETUP |=> card_link_lamp)
		else $error("link lamp dark while connecting");

	AST_LINK_UP: assert property (
		lamps_on && st_ff.link == ccsi_pkg::LINK_UP
		|=> card_link_lamp == $past(link_lit))
		else $error("link lamp off its connected pattern");

	AST_LINK_LOST: assert property (
		lamps_on && st_ff.link == ccsi_pkg::LINK_LOST
		|=> !card_link_lamp)
		else $error("link lamp lit after link lost");

	AST_POWER: assert property (
		lamps_on && power_present |=> power_lamp)
		else $error("power lamp dark with power present");

	AST_RUN_WORK: assert property (
		lamps_on && !card_fault && node == ccsi_pkg::NODE_WORK
		|=> run_lamp)
		else $error("run lamp dark in working state");

	AST_RUN_FAULT: assert property (
		lamps_on && card_fault |=> !run_lamp)
		else $error("run lamp lit on card fault");

	AST_RUN_PREOP: assert property (
		lamps_on && !card_fault && node == ccsi_pkg::NODE_PREOP
		|=> run_lamp == $past(blk_lit))
		else $error("run lamp not blinking in pre-operation");

	AST_RUN_STOP: assert property (
		lamps_on && !card_fault && node != ccsi_pkg::NODE_STOP
		##1 lamps_on && !card_fault && node == ccsi_pkg::NODE_STOP
		|=> run_lamp)
		else $error("stopped flash did not start lit");

	AST_ERR_STEADY: assert property (
		lamps_on && err_steady |=> error_lamp)
		else $error("error lamp dark on bus-off or drive fault");

	AST_ERR_CLEAR: assert property (
		lamps_on && node == ccsi_pkg::NODE_WORK && !err_steady
		&& !addr_invalid && !st_ff.rx_pend |=> !error_lamp)
		else $error("error lamp lit with no error pending");

	AST_ERR_ADDR: assert property (
		lamps_on && !err_steady && addr_invalid
		|=> error_lamp == $past(blk_lit))
		else $error("error lamp not blinking on bad address");

	AST_ERR_RX: assert property (
		rx_first ##1 lamps_on && !err_steady && !addr_invalid
		|-> rx_flash_on)
		else $error("rx error flash did not start");

	AST_IRQ: assert property (
		(|(st_ff.status & st_ff.mask)) == irq)
		else $error("interrupt level differs from masked status");

endmodule
`default_nettype wire

//--- verification/ccsi_board_model.sv
// far side model: drive control board and can controller state lines
// assumes the bench sets wanted levels; outputs change after clk_sys
`timescale 1ns/100ps
`default_nettype none
module ccsi_board_model
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [8:0] want,
	output logic            board_link_ok,
	output logic            power_present,
	output logic            card_fault,
	output logic [1:0]      node_state,
	output logic            bus_off,
	output logic            drive_fault,
	output logic            addr_invalid,
	output logic            rx_error
);
	logic rx_seen_ff; // last rx toggle level seen

	// ------------------------------------------------------------
	// state lines, registered like a real board would drive them
	// ------------------------------------------------------------
	// want: 0 link, 1 power, 2 fault, 4:3 node, 5 busoff, 6 drive
	// fault, 7 bad address, 8 rx toggle (each toggle is one pulse)
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			board_link_ok <= 1'b0;
			power_present <= 1'b0;
			card_fault    <= 1'b0;
			node_state    <= 2'h0;
			bus_off       <= 1'b0;
			drive_fault   <= 1'b0;
			addr_invalid  <= 1'b0;
			rx_error      <= 1'b0;
			rx_seen_ff    <= 1'b0;
		end
		else
		begin
			board_link_ok <= want[0];
			power_present <= want[1];
			card_fault    <= want[2];
			node_state    <= want[4:3];
			bus_off       <= want[5];
			drive_fault   <= want[6];
			addr_invalid  <= want[7];
			rx_error      <= want[8] ^ rx_seen_ff; // one-cycle pulse
			rx_seen_ff    <= want[8];
		end
	end
endmodule
`default_nettype wire

//--- verification/ccsi_top_bench.sv
// self-checking bench of the card status indicator block
// assumes shortened lamp periods: link 5, blink 4, flash gap 10 cycles
`timescale 1ns/100ps
`default_nettype none
module ccsi_top_bench;
	logic        clk_sys, sys_rst;      // clock and reset
	logic        cyc, stb, we;          // wishbone request
	logic [3:0]  adr, sel;
	logic [31:0] wdat, rdat;
	logic        ack;
	logic [8:0]  want;                  // far side wanted state
	logic        lnk, pwr, flt, bof, dfl, bad, rxe, irq;
	logic [1:0]  nst;
	logic        l_link, l_pwr, l_run, l_err;
	logic [3:0]  lamps;
	int          errors, tests_run, n;
	logic [31:0] v;
	assign lamps = {l_err, l_run, l_pwr, l_link};

	ccsi_top #(.LINK_HALF_CYC(5), .BLINK_CYC(4), .FLASH_DK_CYC(10)) dut_u
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.board_link_ok(lnk), .power_present(pwr), .card_fault(flt),
		.node_state(nst), .bus_off(bof), .drive_fault(dfl),
		.addr_invalid(bad), .rx_error(rxe), .card_link_lamp(l_link),
		.power_lamp(l_pwr), .run_lamp(l_run), .error_lamp(l_err),
		.irq(irq)
	);
	ccsi_board_model brd_u
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .want(want),
		.board_link_ok(lnk), .power_present(pwr), .card_fault(flt),
		.node_state(nst), .bus_off(bof), .drive_fault(dfl),
		.addr_invalid(bad), .rx_error(rxe)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// compare and count
	task automatic chk(input logic [31:0] got, exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask
	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [3:0] a, s,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk_sys);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
		@(posedge clk_sys);
		while (ack !== 1'b1 && k < 50)
		begin
			@(posedge clk_sys);
			k++;
		end
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		chk(k < 50, 1, "no ack");
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 4'h0, 32'h0, q);
		chk(q, e, "read");
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, 4'hf, d, q);
	endtask
	// length of the next run of lamp idx at level lvl, capped at 40
	task automatic run_len(input int idx, input logic lvl, input bit skip,
		output int n);
		int k;
		k = 0;
		n = 0;
		while (skip && lamps[idx] === lvl && k < 60)
		begin
			@(negedge clk_sys);
			k++;
		end
		while (lamps[idx] !== lvl && k < 60)
		begin
			@(negedge clk_sys);
			k++;
		end
		while (lamps[idx] === lvl && n < 40)
		begin
			@(negedge clk_sys);
			n++;
		end
	endtask
	task automatic cyc_wait(input int c);
		repeat (c) @(negedge clk_sys);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk(lamps[ccsi_pkg::LAMP_PWR], 0, "power dark");
		run_len(ccsi_pkg::LAMP_LINK, 1, 0, n);
		chk(n, 40, "link steady in setup");
		rd_chk(ccsi_pkg::OFS_CTRL, 32'h1);
		rd_chk(ccsi_pkg::OFS_STATUS, 32'h0);
		rd_chk(ccsi_pkg::OFS_MASK, 32'h0);
		rd_chk(ccsi_pkg::OFS_STATE, 32'h1);
		want[1] <= 1'b1;
		cyc_wait(3);
		chk(lamps[ccsi_pkg::LAMP_PWR], 1, "power lit");
		$display("test reset done");
	endtask
	task automatic t_link();
		want[0] <= 1'b1;
		run_len(ccsi_pkg::LAMP_LINK, 1, 1, n);
		chk(n, 5, "link lit half");
		run_len(ccsi_pkg::LAMP_LINK, 0, 0, n);
		chk(n, 5, "link dark half");
		rd_chk(ccsi_pkg::OFS_STATE, 32'h13);
		wr(ccsi_pkg::OFS_MASK, 32'h1 << ccsi_pkg::EV_LOST);
		want[0] <= 1'b0;
		run_len(ccsi_pkg::LAMP_LINK, 0, 0, n);
		chk(n, 40, "link dark when lost");
		chk(irq, 1, "irq on lost");
		rd_chk(ccsi_pkg::OFS_STATUS, 32'h1 << ccsi_pkg::EV_LOST);
		wr(ccsi_pkg::OFS_STATUS, 32'h1f);
		cyc_wait(2);
		chk(irq, 0, "irq cleared");
		$display("test link done");
	endtask
	task automatic t_run();
		want[4:3] <= ccsi_pkg::NODE_WORK;
		cyc_wait(3);
		run_len(ccsi_pkg::LAMP_RUN, 1, 0, n);
		chk(n, 40, "run steady working");
		want[2] <= 1'b1;
		cyc_wait(3);
		run_len(ccsi_pkg::LAMP_RUN, 0, 0, n);
		chk(n, 40, "run dark on fault");
		want[2] <= 1'b0;
		want[4:3] <= ccsi_pkg::NODE_PREOP;
		// blink runs free, so the first run may be cut: skip it
		run_len(ccsi_pkg::LAMP_RUN, 0, 1, n);
		chk(n, 4, "preop dark");
		run_len(ccsi_pkg::LAMP_RUN, 1, 0, n);
		chk(n, 4, "preop lit");
		want[4:3] <= ccsi_pkg::NODE_STOP;
		run_len(ccsi_pkg::LAMP_RUN, 1, 1, n);
		chk(n, 4, "stop flash lit");
		run_len(ccsi_pkg::LAMP_RUN, 0, 0, n);
		chk(n, 10, "stop flash gap");
		$display("test run done");
	endtask
	task automatic t_err();
		want[4:3] <= ccsi_pkg::NODE_WORK;
		run_len(ccsi_pkg::LAMP_ERR, 0, 0, n);
		chk(n, 40, "err dark working");
		wr(ccsi_pkg::OFS_MASK, 32'h1 << ccsi_pkg::EV_BUSOFF);
		want[5] <= 1'b1;
		want[7] <= 1'b1;
		run_len(ccsi_pkg::LAMP_ERR, 1, 0, n);
		chk(n, 40, "err steady busoff over blink");
		chk(irq, 1, "irq on busoff");
		wr(ccsi_pkg::OFS_MASK, 32'h0);
		cyc_wait(2);
		chk(irq, 0, "irq masked");
		wr(ccsi_pkg::OFS_STATUS, 32'h1f);
		want[5] <= 1'b0;
		want[8] <= ~want[8];
		run_len(ccsi_pkg::LAMP_ERR, 1, 1, n);
		chk(n, 4, "addr blink lit over flash");
		run_len(ccsi_pkg::LAMP_ERR, 0, 0, n);
		chk(n, 4, "addr blink dark");
		want[7] <= 1'b0;
		want[6] <= 1'b1;
		run_len(ccsi_pkg::LAMP_ERR, 1, 0, n);
		chk(n, 40, "err steady drive fault");
		want[6] <= 1'b0;
		cyc_wait(40);
		want[8] <= ~want[8];
		run_len(ccsi_pkg::LAMP_ERR, 1, 0, n);
		chk(n, 4, "rx flash lit");
		run_len(ccsi_pkg::LAMP_ERR, 0, 0, n);
		chk(n, 40, "single flash only");
		$display("test error done");
	endtask
	task automatic t_reg();
		rd_chk(4'h6, 32'h0);
		wr(4'h2, 32'h0);
		rd_chk(ccsi_pkg::OFS_CTRL, 32'h1);
		wb(1'b1, ccsi_pkg::OFS_CTRL, 4'h2, 32'h0, v);
		rd_chk(ccsi_pkg::OFS_CTRL, 32'h1);
		wr(ccsi_pkg::OFS_CTRL, 32'h3);
		cyc_wait(3);
		chk(lamps, 4'hf, "lamp test");
		wr(ccsi_pkg::OFS_CTRL, 32'h0);
		cyc_wait(3);
		chk(lamps, 4'h0, "lamps disabled");
		wr(ccsi_pkg::OFS_CTRL, 32'h1);
		$display("test registers done");
	endtask

	// ------------------------------------------------------------
	// clock, reset, sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial
	begin
		sys_rst = 1'b1;
		{cyc, stb, we} = 3'h0;
		adr = 4'h0;
		sel = 4'h0;
		wdat = 32'h0;
		want = 9'h0;
		errors = 0;
		tests_run = 0;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		t_reset();
		t_link();
		t_run();
		t_err();
		t_reg();
		end_of_test();
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		$display("Error %0t watchdog ran out", $time);
		end_of_test();
	end
endmodule
`default_nettype wire
